//--- verilog/sdr_drive_id_regs.sv
// Drive current registers for channels 2 and 3 plus identification registers
// Operation
// [RL1] Channel 2 drive setting bits 15:11 steer drive only under resistance override.
// [RL2] Channel 3 drive setting bits 15:11 steer drive only under resistance override.
// [RL3] Bits 10:6 capture calibrated drive after each correction unless auto amplitude disabled.
// [RL4] Host writes zeros into channel 2 calibrated field.
// [RL5] Host writes zeros into channel 3 calibrated field.
// [RL6] Read-only 16-bit maker identification at offset 0x7E.
// [RL7] Read-only part identification at offset 0x7F.
// [RL8] Bits 5:0 of both drive registers read zero and ignore writes.
`include "sdr_params.svh"
module sdr_drive_id_regs #(
   parameter logic [15:0] MAKER_ID = `SDR_MAKER_ID_DEF, // Arbitrary value
   parameter logic [15:0] PART_ID = `SDR_PART_ID_DEF, // Arbitrary value
   parameter int NUM_CH = 2
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wr_data,
   output logic [15:0] o_rd_data,
   output logic o_rd_hit,
   input wire logic i_resistance_override_enable,
   input wire logic i_auto_amplitude_disable,
   input wire logic [1:0] i_corr_done,
   input wire logic [9:0] i_measured_drive,
   input wire logic [1:0] i_ch_active,
   output logic [9:0] o_drive_current,
   output logic [1:0] o_drive_override
);
   // Ports and decode are sized for exactly two channels, so refuse anything else at elaboration
   generate
      if (NUM_CH != 2) begin : g_bad_ch
         $error("bank serves exactly channels 2 and 3");
      end
   endgenerate

   sdr_pkg::sdr_drive_t ch2_drive_setting_r;
   sdr_pkg::sdr_drive_t ch3_drive_setting_r;
   sdr_pkg::sdr_drive_t cal_val [NUM_CH];
   sdr_pkg::sdr_word_t rd_data_r;
   sdr_pkg::sdr_word_t rd_data_nxt;
   logic rd_hit_r;
   logic rd_hit_nxt;
   logic [9:0] drive_r;
   logic [1:0] override_r;

   // Host is expected to send zeros in bits 10:6; they are dropped anyway since the field is read-only
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ch2_drive_setting_r <= `SDR_FIELD_RESET;
      end else if (i_wr_en && i_addr == `SDR_ADDR_CH2_DRIVE) begin
         ch2_drive_setting_r <= i_wr_data[`SDR_SET_HI:`SDR_SET_LO]; // [RL1] [RL4]
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ch3_drive_setting_r <= `SDR_FIELD_RESET;
      end else if (i_wr_en && i_addr == `SDR_ADDR_CH3_DRIVE) begin
         ch3_drive_setting_r <= i_wr_data[`SDR_SET_HI:`SDR_SET_LO]; // [RL2] [RL5]
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_cal
         sdr_cal_if cal_bus ();
         assign cal_bus.corr_done = i_corr_done[g];
         assign cal_bus.auto_amplitude_disable = i_auto_amplitude_disable;
         assign cal_bus.measured = i_measured_drive[g*$bits(sdr_pkg::sdr_drive_t) +: $bits(sdr_pkg::sdr_drive_t)];
         assign cal_val[g] = cal_bus.captured;
         sdr_cal_capture u_cap (
            .i_clk_sys(i_clk_sys),
            .i_rst(i_rst),
            .cal(cal_bus.cap)
         );
      end
   endgenerate

   // Override outputs only show the written setting while the override bit is set
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         drive_r <= '0;
         override_r <= '0;
      end else begin
         override_r <= i_ch_active & {2{i_resistance_override_enable}}; // [RL1] [RL2]
         drive_r[4:0] <= i_resistance_override_enable ? ch2_drive_setting_r : cal_val[0]; // [RL1]
         drive_r[9:5] <= i_resistance_override_enable ? ch3_drive_setting_r : cal_val[1]; // [RL2]
      end
   end
   assign o_drive_current = drive_r;
   assign o_drive_override = override_r;

   // Read decode; unmapped addresses read zero with no hit
   always_comb begin
      rd_data_nxt = '0;
      rd_hit_nxt = 1'b0;
      if (i_rd_en) begin
         case (i_addr)
            `SDR_ADDR_CH2_DRIVE: begin
               rd_data_nxt = {ch2_drive_setting_r, cal_val[0], `SDR_RSV_VALUE}; // [RL8]
               rd_hit_nxt = 1'b1;
            end
            `SDR_ADDR_CH3_DRIVE: begin
               rd_data_nxt = {ch3_drive_setting_r, cal_val[1], `SDR_RSV_VALUE}; // [RL8]
               rd_hit_nxt = 1'b1;
            end
            `SDR_ADDR_MAKER_ID: begin
               rd_data_nxt = MAKER_ID; // [RL6]
               rd_hit_nxt = 1'b1;
            end
            `SDR_ADDR_PART_ID: begin
               rd_data_nxt = PART_ID; // [RL7]
               rd_hit_nxt = 1'b1;
            end
            default: begin
               rd_data_nxt = '0;
               rd_hit_nxt = 1'b0;
            end
         endcase
      end
   end

   // Data holds until the next read so a slow host can still pick it up; the hit is a one-cycle pulse
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rd_data_r <= '0;
         rd_hit_r <= 1'b0;
      end else begin
         rd_hit_r <= rd_hit_nxt;
         if (i_rd_en) begin
            rd_data_r <= rd_data_nxt;
         end
      end
   end
   assign o_rd_data = rd_data_r;
   assign o_rd_hit = rd_hit_r;

   // Write path
   ch2_write_a: assert property ( // [RL1]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_wr_en && i_addr == `SDR_ADDR_CH2_DRIVE) |=> ch2_drive_setting_r == $past(i_wr_data[`SDR_SET_HI:`SDR_SET_LO]))
      else $error("channel 2 setting not stored");
   ch3_write_a: assert property ( // [RL2]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_wr_en && i_addr == `SDR_ADDR_CH3_DRIVE) |=> ch3_drive_setting_r == $past(i_wr_data[`SDR_SET_HI:`SDR_SET_LO]))
      else $error("channel 3 setting not stored");
   ch2_write_isolated_a: assert property ( // [RL2]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_wr_en && i_addr == `SDR_ADDR_CH2_DRIVE) |=> $stable(ch3_drive_setting_r))
      else $error("channel 3 setting disturbed");
   ch3_write_isolated_a: assert property ( // [RL1]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_wr_en && i_addr == `SDR_ADDR_CH3_DRIVE) |=> $stable(ch2_drive_setting_r))
      else $error("channel 2 setting disturbed");
   id_write_ignored_a: assert property ( // [RL6]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_wr_en && (i_addr == `SDR_ADDR_MAKER_ID || i_addr == `SDR_ADDR_PART_ID))
      |=> $stable(ch2_drive_setting_r) && $stable(ch3_drive_setting_r))
      else $error("identification write changed a setting");
   cal2_write_ignore_a: assert property ( // [RL3]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_wr_en && i_addr == `SDR_ADDR_CH2_DRIVE) |=> (cal_val[0] == $past(cal_val[0])) || $past(i_corr_done[0]))
      else $error("write reached channel 2 calibrated field");
   cal3_write_ignore_a: assert property ( // [RL3]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_wr_en && i_addr == `SDR_ADDR_CH3_DRIVE) |=> (cal_val[1] == $past(cal_val[1])) || $past(i_corr_done[1]))
      else $error("write reached channel 3 calibrated field");

   // Drive selection
   override_use_a: assert property ( // [RL1]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_resistance_override_enable && !i_wr_en) |=> o_drive_current[4:0] == ch2_drive_setting_r)
      else $error("override drive not applied");
   ch3_override_a: assert property ( // [RL2]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_resistance_override_enable && !i_wr_en) |=> o_drive_current[9:5] == ch3_drive_setting_r)
      else $error("channel 3 override drive not applied");
   ch2_cal_drive_a: assert property ( // [RL1]
      @(posedge i_clk_sys) disable iff (i_rst)
      !i_resistance_override_enable |=> o_drive_current[4:0] == $past(cal_val[0]))
      else $error("channel 2 setting used without override");
   ch3_cal_drive_a: assert property ( // [RL2]
      @(posedge i_clk_sys) disable iff (i_rst)
      !i_resistance_override_enable |=> o_drive_current[9:5] == $past(cal_val[1]))
      else $error("channel 3 setting used without override");
   override_flag_a: assert property ( // [RL1]
      @(posedge i_clk_sys) disable iff (i_rst)
      1'b1 |=> o_drive_override == ($past(i_ch_active) & {2{$past(i_resistance_override_enable)}}))
      else $error("override flag wrong");
   override_clear_a: assert property ( // [RL2]
      @(posedge i_clk_sys) disable iff (i_rst)
      !i_resistance_override_enable |=> o_drive_override == '0)
      else $error("override flag set without enable");

   // Calibrated capture
   cal_capture_a: assert property ( // [RL3]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_corr_done[1] && !i_auto_amplitude_disable) |=> cal_val[1] == $past(i_measured_drive[9:5]))
      else $error("calibrated drive not captured");
   ch2_capture_a: assert property ( // [RL3]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_corr_done[0] && !i_auto_amplitude_disable) |=> cal_val[0] == $past(i_measured_drive[4:0]))
      else $error("channel 2 calibrated drive not captured");
   ch2_cal_hold_a: assert property ( // [RL3]
      @(posedge i_clk_sys) disable iff (i_rst)
      i_auto_amplitude_disable |=> cal_val[0] == $past(cal_val[0]))
      else $error("channel 2 capture while disabled");
   ch3_cal_hold_a: assert property ( // [RL3]
      @(posedge i_clk_sys) disable iff (i_rst)
      i_auto_amplitude_disable |=> cal_val[1] == $past(cal_val[1]))
      else $error("channel 3 capture while disabled");

   // Read path
   reserved_zero_a: assert property ( // [RL8]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_rd_en && (i_addr == `SDR_ADDR_CH2_DRIVE || i_addr == `SDR_ADDR_CH3_DRIVE))
      |=> o_rd_data[`SDR_RSV_HI:`SDR_RSV_LO] == '0)
      else $error("reserved bits not zero");
   maker_read_a: assert property ( // [RL6]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_rd_en && i_addr == `SDR_ADDR_MAKER_ID) |=> o_rd_hit && o_rd_data == MAKER_ID)
      else $error("maker id wrong");
   part_read_a: assert property ( // [RL7]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_rd_en && i_addr == `SDR_ADDR_PART_ID) |=> o_rd_hit && o_rd_data == PART_ID)
      else $error("part id wrong");
   cal_readback_a: assert property ( // [RL3]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_rd_en && i_addr == `SDR_ADDR_CH2_DRIVE) |=> o_rd_data[`SDR_CAL_HI:`SDR_CAL_LO] == $past(cal_val[0]))
      else $error("calibrated readback wrong");
   ch3_cal_readback_a: assert property ( // [RL3]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_rd_en && i_addr == `SDR_ADDR_CH3_DRIVE) |=> o_rd_data[`SDR_CAL_HI:`SDR_CAL_LO] == $past(cal_val[1]))
      else $error("channel 3 calibrated readback wrong");
   ch2_set_readback_a: assert property ( // [RL1]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_rd_en && i_addr == `SDR_ADDR_CH2_DRIVE)
      |=> o_rd_data[`SDR_SET_HI:`SDR_SET_LO] == $past(ch2_drive_setting_r))
      else $error("channel 2 setting readback wrong");
   ch3_set_readback_a: assert property ( // [RL2]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_rd_en && i_addr == `SDR_ADDR_CH3_DRIVE)
      |=> o_rd_data[`SDR_SET_HI:`SDR_SET_LO] == $past(ch3_drive_setting_r))
      else $error("channel 3 setting readback wrong");
   ch2_read_hit_a: assert property ( // [RL1]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_rd_en && i_addr == `SDR_ADDR_CH2_DRIVE) |=> o_rd_hit)
      else $error("channel 2 read not acknowledged");
   ch3_read_hit_a: assert property ( // [RL2]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_rd_en && i_addr == `SDR_ADDR_CH3_DRIVE) |=> o_rd_hit)
      else $error("channel 3 read not acknowledged");
   unmapped_read_a: assert property ( // [RL8]
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_rd_en && !(i_addr inside {`SDR_ADDR_CH2_DRIVE, `SDR_ADDR_CH3_DRIVE, `SDR_ADDR_MAKER_ID, `SDR_ADDR_PART_ID}))
      |=> !o_rd_hit && o_rd_data == '0)
      else $error("unmapped read answered");
   hit_pulse_a: assert property ( // [RL6]
      @(posedge i_clk_sys) disable iff (i_rst)
      !i_rd_en |=> !o_rd_hit)
      else $error("read hit without a read");
   rd_data_hold_a: assert property ( // [RL7]
      @(posedge i_clk_sys) disable iff (i_rst)
      !i_rd_en |=> $stable(o_rd_data))
      else $error("read data changed between reads");
endmodule

//--- verilog/sdr_params.svh
// Register offsets, field positions and reset values of the drive and identification bank
`ifndef SDR_PARAMS_SVH
`define SDR_PARAMS_SVH
`define SDR_ADDR_CH2_DRIVE 8'h20
`define SDR_ADDR_CH3_DRIVE 8'h21
`define SDR_ADDR_MAKER_ID 8'h7e
`define SDR_ADDR_PART_ID 8'h7f
`define SDR_SET_HI 15
`define SDR_SET_LO 11
`define SDR_CAL_HI 10
`define SDR_CAL_LO 6
`define SDR_RSV_HI 5
`define SDR_RSV_LO 0
`define SDR_FIELD_RESET 5'h00
`define SDR_RSV_VALUE 6'h00
`define SDR_MAKER_ID_DEF 16'h0a5c
`define SDR_PART_ID_DEF 16'h0c3a
`endif

//--- verilog/sdr_pkg.sv
// Types shared by the drive and identification bank
package sdr_pkg;
   typedef logic [4:0] sdr_drive_t;
   typedef logic [15:0] sdr_word_t;
   typedef logic [7:0] sdr_addr_t;
endpackage

//--- verilog/sdr_cal_if.sv
// Carrier between the register bank and one channel's calibrated drive capture
interface sdr_cal_if;
   logic corr_done;
   logic auto_amplitude_disable;
   sdr_pkg::sdr_drive_t measured;
   sdr_pkg::sdr_drive_t captured;
   modport bank (output corr_done, output auto_amplitude_disable, output measured, input captured);
   modport cap (input corr_done, input auto_amplitude_disable, input measured, output captured);
endinterface

//--- verilog/sdr_cal_capture.sv
// Holds one channel's calibrated initial drive current
`include "sdr_params.svh"
module sdr_cal_capture (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   sdr_cal_if.cap cal
);
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         cal.captured <= `SDR_FIELD_RESET;
      end else if (cal.corr_done && !cal.auto_amplitude_disable) begin
         cal.captured <= cal.measured; // [RL3]
      end
   end

   capture_hold_a: assert property ( // [RL3]
      @(posedge i_clk_sys) disable iff (i_rst)
      !(cal.corr_done && !cal.auto_amplitude_disable) |=> $stable(cal.captured))
      else $error("calibrated drive changed without a correction phase");
endmodule

//--- tb/sdr_host_model.sv
// Host side model issuing register reads and writes
module sdr_host_model (
   input wire logic i_clk_sys,
   input wire logic [15:0] i_rd_data,
   input wire logic i_rd_hit,
   output logic o_wr_en,
   output logic o_rd_en,
   output logic [7:0] o_addr,
   output logic [15:0] o_wr_data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr = 8'h00;
      o_wr_data = 16'h0000;
   end
   task automatic wr(input logic [7:0] a, input logic [4:0] s);
      @(posedge i_clk_sys);
      o_wr_en <= 1'b1;
      o_addr <= a;
      o_wr_data <= {s, 5'h00, 6'h00};
      @(posedge i_clk_sys);
      o_wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic h);
      @(posedge i_clk_sys);
      o_rd_en <= 1'b1;
      o_addr <= a;
      @(posedge i_clk_sys);
      o_rd_en <= 1'b0;
      #1;
      d = i_rd_data;
      h = i_rd_hit;
   endtask
endmodule

//--- tb/sdr_drive_id_regs_tb_top.sv
// Self-checking bench of the drive and identification bank
`include "sdr_params.svh"
module sdr_drive_id_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk_sys, i_rst, wr_en, rd_en, hit, ovr, aad, h;
   logic [7:0] addr;
   logic [15:0] wdat, rdat, d;
   logic [1:0] corr, act, dovr;
   logic [9:0] meas, dcur;
   int error_cnt = 0;
   int n_compared = 0;
   int cyc = 0;
   sdr_drive_id_regs dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wr_en(wr_en), .i_rd_en(rd_en),
      .i_addr(addr), .i_wr_data(wdat), .o_rd_data(rdat), .o_rd_hit(hit),
      .i_resistance_override_enable(ovr), .i_auto_amplitude_disable(aad), .i_corr_done(corr),
      .i_measured_drive(meas), .i_ch_active(act), .o_drive_current(dcur), .o_drive_override(dovr));
   sdr_host_model host (.i_clk_sys(i_clk_sys), .i_rd_data(rdat), .i_rd_hit(hit), .o_wr_en(wr_en),
      .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wdat));
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Whole run needs well under a thousand cycles
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic t_ids;
      host.wr(8'h7e, 5'h1f);
      host.rd(8'h7e, d, h);
      chk(d, `SDR_MAKER_ID_DEF);
      chk({15'h0000, h}, 16'h0001);
      host.rd(8'h7f, d, h);
      chk(d, `SDR_PART_ID_DEF);
      chk({15'h0000, h}, 16'h0001);
      host.rd(8'h21, d, h);
      chk(d, 16'h0000);
      host.rd(8'h22, d, h);
      chk({h, d[14:0]}, 16'h0000);
   endtask
   task automatic t_override;
      @(posedge i_clk_sys);
      ovr <= 1'b1;
      act <= 2'b11;
      host.wr(8'h20, 5'h0a);
      host.wr(8'h21, 5'h1f);
      host.rd(8'h20, d, h);
      chk(d, 16'h5000);
      chk({6'h00, dcur}, {6'h00, 5'h1f, 5'h0a});
      chk({14'h0000, dovr}, 16'h0003);
      @(posedge i_clk_sys);
      act <= 2'b01;
      repeat (2) @(posedge i_clk_sys);
      #1;
      chk({14'h0000, dovr}, 16'h0001);
   endtask
   task automatic t_capture;
      @(posedge i_clk_sys);
      ovr <= 1'b0;
      meas <= {5'h03, 5'h15};
      corr <= 2'b11;
      @(posedge i_clk_sys);
      corr <= 2'b00;
      aad <= 1'b1;
      host.rd(8'h21, d, h);
      chk(d, 16'hf8c0);
      chk({6'h00, dcur}, {6'h00, 5'h03, 5'h15});
      @(posedge i_clk_sys);
      meas <= 10'h3ff;
      corr <= 2'b11;
      @(posedge i_clk_sys);
      corr <= 2'b00;
      host.rd(8'h20, d, h);
      chk(d, 16'h5540);
   endtask
   initial begin
      i_rst = 1'b1;
      {ovr, aad, corr, act, meas} = '0;
      repeat (16) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      t_ids();
      t_override();
      t_capture();
      tally_and_finish();
   end
endmodule
